// file: verification/testbench.sv
`timescale 1ns/100ps
module testbench;
    import rsf_pkg::*;

    // ************************************************
    // Stimulus table and signals
    // ************************************************
    typedef struct packed {
        logic [15:0] instr;
        logic        ext;
        logic [11:0] addr;
        logic [7:0]  init;
    } rsf_row_t;

    logic        core_clk = 1'b0;
    logic        resetn   = 1'b1;
    logic        hsel     = 1'b0;
    logic [31:0] haddr    = 32'h0;
    logic [1:0]  htrans   = 2'h0;
    logic        hwrite   = 1'b0;
    logic [2:0]  hsize    = 3'h2;
    logic [31:0] hwdata   = 32'h0;
    wire logic   hready;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        busy;
    int          bad_count   = 0;
    int          comparisons = 0;

    // The first set row follows a rotate that leaves Z set; the other two follow rows that leave N and Z clear.
    rsf_row_t rows [8] = '{
        '{16'h4210, 1'b0, 12'h010, 8'hd7}, '{16'h4070, 1'b0, 12'hf70, 8'h01},
        '{16'h4322, 1'b0, 12'h322, 8'h00}, '{16'h6800, 1'b1, 12'h200, 8'h3c},
        '{16'h425f, 1'b1, 12'h25f, 8'h02}, '{16'h4260, 1'b1, 12'hf60, 8'h80},
        '{16'h69ff, 1'b0, 12'h3ff, 8'h00}, '{16'h68ff, 1'b0, 12'hfff, 8'h12}};

    always #4 core_clk = ~core_clk;
    assign hready = hreadyout;

    rsf_top i_rsf_top (
        .core_clk  (core_clk),
        .resetn    (resetn),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hwdata    (hwdata),
        .hready    (hready),
        .hrdata    (hrdata),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .busy      (busy)
    );

    // ************************************************
    // Bus and check tasks
    // ************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t: %s seen %h expected %h", $time, what, seen,
                     exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge core_clk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr  <= {20'h0, a};
        // Only the watchdog ends a wait for the slave.
        do begin
            @(posedge core_clk);
        end while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do begin
            @(posedge core_clk);
        end while (hready !== 1'b1);
        rd = hrdata;
        hsel <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        bus(1'b0, a, 32'h0, d);
    endtask

    // Counts the cycles that busy stays high after the instruction lands.
    task automatic exec(input logic [15:0] w, output int cyc);
        wr(REG_INSTR, {16'h0, w});
        #1;
        cyc = 0;
        while (busy === 1'b1 && cyc < 20) begin
            @(posedge core_clk);
            #1;
            cyc++;
        end
    endtask

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge core_clk);
        bad_count++;
        $display("ERROR %0t: watchdog expired", $time);
        print_verdict();
    end

    // ************************************************
    // Main sequence
    // ************************************************
    initial begin
        rsf_row_t    r;
        logic        rot;
        logic [7:0]  res;
        logic [31:0] v;
        logic [31:0] st0;
        int          cyc;
        static logic [15:0] bad_words [2] = '{16'h4c12, 16'h6a12};
        // Driven at time zero by a nonblocking assignment so that the reset edge is seen.
        resetn <= 1'b0;
        repeat (5) @(posedge core_clk);
        resetn <= 1'b1;
        wr(REG_BSR, 32'h3);
        wr(REG_FSR2, 32'h200);
        foreach (rows[i]) begin
            r   = rows[i];
            rot = (r.instr[15:10] == 6'b010000);
            res = {r.init[0], r.init[7:1]};
            wr(REG_CTRL, {31'h0, r.ext});
            wr(REG_WREG, 32'h5a);
            wr(REG_MADDR, {20'h0, r.addr});
            wr(REG_MDATA, {24'h0, r.init});
            wr(REG_STATUS, 32'h1 << STAT_DONE_BIT);
            rd(REG_STATUS, st0);
            exec(r.instr, cyc);
            check(cyc, 4, "busy cycles");
            rd(REG_MDATA, v);
            check(v, rot ? (r.instr[9] ? res : r.init) : 8'hff, "file");
            rd(REG_WREG, v);
            check(v, (rot && !r.instr[9]) ? res : 8'h5a, "wreg");
            rd(REG_STATUS, v);
            check(v[STAT_N_BIT], rot ? res[7] : st0[STAT_N_BIT], "n");
            check(v[STAT_Z_BIT], rot ? (res == 0) : st0[STAT_Z_BIT], "z");
            check(v[STAT_DONE_BIT], 1'b1, "done");
            $display("row %0d finished", i);
        end
        // Near-miss words must not touch memory.
        foreach (bad_words[i]) begin
            wr(REG_MADDR, 32'h012);
            wr(REG_MDATA, 32'h55);
            exec(bad_words[i], cyc);
            check(cyc, 1, "illegal busy cycles");
            rd(REG_MDATA, v);
            check(v, 32'h55, "illegal word file");
            rd(REG_STATUS, v);
            check(v[STAT_ILL_BIT], 1'b1, "illegal flag");
            wr(REG_STATUS, 32'h1 << STAT_ILL_BIT);
            rd(REG_STATUS, v);
            check(v[STAT_ILL_BIT], 1'b0, "illegal clear");
        end
        $display("illegal word test finished");
        rd(12'h020, v);
        check(v, 32'h0, "unmapped read");
        $display("unmapped read test finished");
        // A reset in mid-instruction must drop busy at once.
        wr(REG_INSTR, 32'h69ff);
        @(posedge core_clk);
        resetn <= 1'b0;
        @(posedge core_clk);
        #1;
        check(busy, 1'b0, "busy in reset");
        check(hreadyout, 1'b1, "ready in reset");
        check(hresp, 1'b0, "resp in reset");
        check(hrdata, 32'h0, "rdata in reset");
        @(posedge core_clk);
        resetn <= 1'b1;
        rd(REG_STATUS, v);
        check(v[STAT_BUSY_BIT], 1'b0, "busy after reset");
        $display("reset test finished");
        print_verdict();
    end
endmodule

// file: verilog/rsf_alu.sv
`timescale 1ns/100ps
module rsf_alu (
    // Decoder and data path
    rsf_alu_if.alu a
);
    import rsf_pkg::*;

    assign a.is_rot    = (a.instr[15:10] == ROT_OPC);
    assign a.is_set    = (a.instr[15:9] == SET_OPC);
    assign a.to_file   = a.is_set | a.instr[DEST_BIT];
    assign a.bank_a    = a.instr[BANK_BIT];
    assign a.file_addr = a.instr[7:0];
    // Rotate moves bit n to n-1 and bit 0 up to bit 7.
    assign a.result    = a.is_set ? SET_VALUE
                                  : {a.operand[0], a.operand[7:1]};
    assign a.flags_upd = a.is_rot;
    assign a.flag_n    = a.result[7];
    assign a.flag_z    = (a.result == RST_BYTE);
endmodule

// file: verilog/rsf_alu_if.sv
`timescale 1ns/100ps
interface rsf_alu_if;
    logic [15:0] instr;
    logic [7:0]  operand;
    logic        is_rot;
    logic        is_set;
    logic        to_file;
    logic        bank_a;
    logic [7:0]  file_addr;
    logic [7:0]  result;
    logic        flags_upd;
    logic        flag_n;
    logic        flag_z;

    modport alu (
        input  instr, operand,
        output is_rot, is_set, to_file, bank_a, file_addr, result,
        output flags_upd, flag_n, flag_z
    );
    modport core (
        output instr, operand,
        input  is_rot, is_set, to_file, bank_a, file_addr, result,
        input  flags_upd, flag_n, flag_z
    );
endinterface

// file: verilog/rsf_pkg.sv
package rsf_pkg;

    // ****************************************************************
    // Register map, byte offsets on the bus
    // ****************************************************************
    localparam logic [11:0] REG_CTRL   = 12'h000;
    localparam logic [11:0] REG_INSTR  = 12'h004;
    localparam logic [11:0] REG_STATUS = 12'h008;
    localparam logic [11:0] REG_WREG   = 12'h00c;
    localparam logic [11:0] REG_BSR    = 12'h010;
    localparam logic [11:0] REG_FSR2   = 12'h014;
    localparam logic [11:0] REG_MADDR  = 12'h018;
    localparam logic [11:0] REG_MDATA  = 12'h01c;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int CTRL_EXT_BIT  = 0;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DONE_BIT = 1;
    localparam int STAT_ILL_BIT  = 2;
    localparam int STAT_Z_BIT    = 3;
    localparam int STAT_N_BIT    = 4;
    localparam int DEST_BIT      = 9;
    localparam int BANK_BIT      = 8;

    // ****************************************************************
    // Encodings and constants
    // ****************************************************************
    localparam logic [5:0]  ROT_OPC        = 6'h10;
    localparam logic [6:0]  SET_OPC        = 7'h34;
    localparam logic [7:0]  SET_VALUE      = 8'hff;
    localparam logic [7:0]  INDEXED_LIMIT  = 8'h5f;
    localparam logic [7:0]  ACCESS_SPLIT   = 8'h60;
    localparam logic [3:0]  ACCESS_LO_BANK = 4'h0;
    localparam logic [3:0]  ACCESS_HI_BANK = 4'hf;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [7:0]  RST_BYTE  = 8'h00;
    localparam logic [11:0] RST_ADDR  = 12'h000;
    localparam logic [15:0] RST_INSTR = 16'h0000;
    localparam logic [31:0] RST_WORD  = 32'h0000_0000;

    typedef enum logic [4:0] {
        RSF_IDLE   = 5'h01,
        RSF_DECODE = 5'h02,
        RSF_READ   = 5'h04,
        RSF_PROC   = 5'h08,
        RSF_WRITE  = 5'h10
    } rsf_phase_t;

endpackage

// file: verilog/rsf_top.sv
`timescale 1ns/100ps
// Behaviour
// - Rotate right without carry: bit n to n-1, bit 0 to 7; set N, Z.
// - Destination bit 1 writes the file register, 0 writes the W register.
// - Set operation writes FFh to the file register, flags untouched.
// - Bank bit 0 picks the access bank, 1 the bank-select register bank.
// - Bank 0, extended set on and f at most 5Fh: indexed offset address.
// - Set operation word is 0110100, bank bit, then 8-bit file address.
// - Rotate word is 0100, two zeros, dest bit, bank bit, file address.
// - File operand is unsigned 0 to 255; bank bit is a single bit.
module rsf_top (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        resetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Status
    output logic             busy
);
    import rsf_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        rsf_phase_t  phase;
        logic        ext_en;
        logic [15:0] instr;
        logic [7:0]  wreg;
        logic [3:0]  bank_select_reg;
        logic [11:0] fsr2;
        logic [11:0] maddr;
        logic [11:0] ea;
        logic [7:0]  operand;
        logic [7:0]  result;
        logic        flag_n;
        logic        flag_z;
        logic        done;
        logic        illegal;
        logic        wr_pend;
        logic [11:0] addr;
        logic [31:0] rdata;
        logic        ready;
        logic        busy;
    } rsf_top_state_t;

    localparam rsf_top_state_t RST_STATE = '{
        phase: RSF_IDLE, ext_en: 1'b0, instr: RST_INSTR, wreg: RST_BYTE,
        bank_select_reg: ACCESS_LO_BANK, fsr2: RST_ADDR, maddr: RST_ADDR,
        ea: RST_ADDR, operand: RST_BYTE, result: RST_BYTE,
        flag_n: 1'b0, flag_z: 1'b0, done: 1'b0, illegal: 1'b0,
        wr_pend: 1'b0, addr: RST_ADDR, rdata: RST_WORD, ready: 1'b1,
        busy: 1'b0};

    rsf_top_state_t q;
    rsf_top_state_t d;

    // Data memory has no reset; software loads it through the window.
    logic [7:0]  mem [0:4095];
    logic        mem_we;
    logic [11:0] mem_wa;
    logic [7:0]  mem_wd;
    logic        idle;

    rsf_alu_if alu_bus ();

    assign alu_bus.instr   = q.instr;
    assign alu_bus.operand = q.operand;

    rsf_alu u_alu (
        .a (alu_bus.alu)
    );

    assign hrdata    = q.rdata;
    assign hreadyout = q.ready;
    assign hresp     = 1'b0;
    assign busy      = q.busy;
    assign idle      = (q.phase == RSF_IDLE);

    // ****************************************************************
    // Register read view
    // ****************************************************************
    function automatic logic [31:0] rd_mux(input logic [11:0] ad);
        logic [31:0] v;
        v = RST_WORD;
        unique case (ad)
            REG_CTRL:   v[CTRL_EXT_BIT] = q.ext_en;
            REG_INSTR:  v[15:0] = q.instr;
            REG_STATUS: begin
                v[STAT_BUSY_BIT] = ~idle;
                v[STAT_DONE_BIT] = q.done;
                v[STAT_ILL_BIT]  = q.illegal;
                v[STAT_Z_BIT]    = q.flag_z;
                v[STAT_N_BIT]    = q.flag_n;
            end
            REG_WREG:   v[7:0] = q.wreg;
            REG_BSR:    v[3:0] = q.bank_select_reg;
            REG_FSR2:   v[11:0] = q.fsr2;
            REG_MADDR:  v[11:0] = q.maddr;
            REG_MDATA:  v[7:0] = mem[q.maddr];
            default:    v = RST_WORD;
        endcase
        return v;
    endfunction

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        d      = q;
        mem_we = 1'b0;
        mem_wa = q.maddr;
        mem_wd = hwdata[7:0];

        // Zero-wait slave: read data is latched at the address phase.
        d.wr_pend = 1'b0;
        if (hsel && hready && htrans[1]) begin
            d.wr_pend = hwrite;
            d.addr    = haddr[11:0];
            if (!hwrite) begin
                d.rdata = rd_mux(haddr[11:0]);
            end
        end

        // Configuration is frozen while an instruction runs so that the
        // operand address cannot move under it.
        if (q.wr_pend) begin
            unique case (q.addr)
                REG_CTRL: begin
                    if (idle) begin
                        d.ext_en = hwdata[CTRL_EXT_BIT];
                    end
                end
                REG_INSTR: begin
                    if (idle) begin
                        d.instr = hwdata[15:0];
                        d.phase = RSF_DECODE;
                    end
                end
                REG_STATUS: begin
                    if (hwdata[STAT_DONE_BIT]) begin
                        d.done = 1'b0;
                    end
                    if (hwdata[STAT_ILL_BIT]) begin
                        d.illegal = 1'b0;
                    end
                end
                REG_WREG: begin
                    if (idle) begin
                        d.wreg = hwdata[7:0];
                    end
                end
                REG_BSR: begin
                    if (idle) begin
                        d.bank_select_reg = hwdata[3:0];
                    end
                end
                REG_FSR2: begin
                    if (idle) begin
                        d.fsr2 = hwdata[11:0];
                    end
                end
                REG_MADDR: begin
                    if (idle) begin
                        d.maddr = hwdata[11:0];
                    end
                end
                REG_MDATA: begin
                    if (idle) begin
                        mem_we = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end

        // Sets below come after the clears above, so a set wins.
        unique case (q.phase)
            RSF_IDLE: begin
            end
            RSF_DECODE: begin
                if (!(alu_bus.is_rot || alu_bus.is_set)) begin
                    d.illegal = 1'b1;
                    d.phase   = RSF_IDLE;
                end else begin
                    if (alu_bus.bank_a) begin
                        d.ea = {q.bank_select_reg, alu_bus.file_addr};
                    end else if (q.ext_en &&
                                 alu_bus.file_addr <= INDEXED_LIMIT) begin
                        d.ea = q.fsr2 + {ACCESS_LO_BANK,
                                         alu_bus.file_addr};
                    end else if (alu_bus.file_addr < ACCESS_SPLIT) begin
                        d.ea = {ACCESS_LO_BANK, alu_bus.file_addr};
                    end else begin
                        d.ea = {ACCESS_HI_BANK, alu_bus.file_addr};
                    end
                    d.phase = RSF_READ;
                end
            end
            RSF_READ: begin
                d.operand = mem[q.ea];
                d.phase   = RSF_PROC;
            end
            RSF_PROC: begin
                d.result = alu_bus.result;
                d.phase  = RSF_WRITE;
            end
            RSF_WRITE: begin
                if (alu_bus.to_file) begin
                    mem_we = 1'b1;
                    mem_wa = q.ea;
                    mem_wd = q.result;
                end else begin
                    d.wreg = q.result;
                end
                if (alu_bus.flags_upd) begin
                    d.flag_n = q.result[7];
                    d.flag_z = (q.result == RST_BYTE);
                end
                d.done  = 1'b1;
                d.phase = RSF_IDLE;
            end
        endcase
        d.busy = (d.phase != RSF_IDLE);
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            q <= RST_STATE;
        end else begin
            q <= d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    sequence s_phases;
        q.phase == RSF_READ ##1 q.phase == RSF_PROC
        ##1 q.phase == RSF_WRITE ##1 q.phase == RSF_IDLE;
    endsequence

    sequence s_legal_decode;
        q.phase == RSF_DECODE && (alu_bus.is_rot || alu_bus.is_set);
    endsequence

    AST_PHASE_ORDER: assert property (s_legal_decode |=> s_phases)
        else $error("phase order broken");
    AST_ROT_VALUE: assert property (q.phase == RSF_PROC && alu_bus.is_rot
        |=> q.result == {$past(q.operand[0]), $past(q.operand[7:1])})
        else $error("rotate result wrong");
    AST_ROT_FLAGS: assert property (q.phase == RSF_WRITE && alu_bus.is_rot
        |=> q.flag_n == $past(q.result[7])
            && q.flag_z == ($past(q.result) == RST_BYTE))
        else $error("rotate flags wrong");
    AST_DEST_W: assert property (q.phase == RSF_WRITE && !alu_bus.to_file
        |=> q.wreg == $past(q.result) && $stable(mem[q.ea]))
        else $error("W destination wrong");
    AST_DEST_F: assert property (q.phase == RSF_WRITE && alu_bus.to_file
        |=> mem[$past(q.ea)] == $past(q.result) && $stable(q.wreg))
        else $error("file destination wrong");
    // The result register is loaded at the end of the process phase, three
    // cycles after decode; the flags must then hold across the write.
    AST_SET_FF: assert property (
        (s_legal_decode and alu_bus.is_set)
        |-> ##3 q.result == SET_VALUE ##1 $stable({q.flag_n, q.flag_z}))
        else $error("set result or flags wrong");
    AST_BANK_SEL: assert property (
        (s_legal_decode and alu_bus.bank_a)
        |=> q.ea == {q.bank_select_reg, q.instr[7:0]})
        else $error("bank select address wrong");
    AST_INDEXED: assert property (
        (s_legal_decode and (!alu_bus.bank_a && q.ext_en
                             && q.instr[7:0] <= INDEXED_LIMIT))
        |=> q.ea == q.fsr2 + {ACCESS_LO_BANK, q.instr[7:0]})
        else $error("indexed address wrong");
    AST_ILLEGAL: assert property (q.phase == RSF_DECODE
        && !alu_bus.is_rot && !alu_bus.is_set
        |=> q.phase == RSF_IDLE && q.illegal)
        else $error("illegal word not refused");
endmodule
